// ---- rtl/dsw_params.svh ----
`ifndef DSW_PARAMS_SVH
`define DSW_PARAMS_SVH
// ****************************************
// clock and timing
// ****************************************
`define DSW_CLK_MHZ 100
`define DSW_CELL_DD_NS 2000
`define DSW_CELL_SD_NS 4000
`define DSW_CELL_DD_CYC ((`DSW_CELL_DD_NS * `DSW_CLK_MHZ) / 1000)
`define DSW_CELL_SD_CYC ((`DSW_CELL_SD_NS * `DSW_CLK_MHZ) / 1000)
`define DSW_BITS_PER_BYTE 8
`define DSW_BYTE_SLOW_SD_CYC (2 * `DSW_BITS_PER_BYTE * `DSW_CELL_SD_CYC)
`define DSW_GATE_SD_NS 2000
`define DSW_GATE_DD_NS 1000
`define DSW_GATE_SD_CYC ((`DSW_GATE_SD_NS * `DSW_CLK_MHZ) / 1000)
`define DSW_GATE_DD_CYC ((`DSW_GATE_DD_NS * `DSW_CLK_MHZ) / 1000)
// ****************************************
// register map
// ****************************************
`define DSW_ADDR_STATUS 4'h0
`define DSW_ADDR_CONTROL 4'h4
`define DSW_ADDR_DATA 4'h8
`define DSW_CTRL_CLASS_LSB 0
`define DSW_CTRL_DD_BIT 3
`define DSW_CTRL_SLOW_BIT 4
`define DSW_CTRL_REFUSED_BIT 6
`define DSW_CTRL_START_BIT 7
`define DSW_CTRL_RESET 8'h00
`define DSW_DATA_RESET 8'h00
`define DSW_STATUS_NOT_READY 7
`define DSW_STATUS_BUSY 0
`endif

// ---- rtl/dsw_pkg.sv ----
package dsw_pkg;
  typedef enum logic [2:0] {
    DSW_CLASS_POSITION = 3'b000,
    DSW_CLASS_READ_ADDR = 3'b001,
    DSW_CLASS_READ_SECTOR = 3'b010,
    DSW_CLASS_READ_TRACK = 3'b011,
    DSW_CLASS_WRITE_SECTOR = 3'b100,
    DSW_CLASS_WRITE_TRACK = 3'b101
  } dsw_class_t;
  typedef enum logic [1:0] {
    DSW_GATE_IDLE = 2'b00,
    DSW_GATE_LEAD = 2'b01,
    DSW_GATE_ACTIVE = 2'b10,
    DSW_GATE_TRAIL = 2'b11
  } dsw_gate_t;
  // drive pins; the active-low ones are marked _n
  typedef struct packed {
    logic ready;
    logic write_protect_input_n;
    logic head_engage_input;
    logic track_zero_input_n;
    logic index_pulse_input_n;
  } dsw_drive_t;
  // one-cycle events from the disk engine
  typedef struct packed {
    logic cmd_done;
    logic seek_error;
    logic crc_error;
    logic record_missing_flag;
    logic deleted_mark;
    logic write_fault;
    logic write_protect_hit;
  } dsw_event_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dsw_wb_req_t;
endpackage : dsw_pkg

// ---- rtl/dsw_status_word.sv ----
`timescale 1ns/1ps
`include "dsw_params.svh"
module dsw_status_word #(
  parameter int unsigned BYTE_SLOW_SD_CYCLES = `DSW_BYTE_SLOW_SD_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_reset_input,
  input wire dsw_pkg::dsw_drive_t drive_i,
  input wire dsw_pkg::dsw_event_t event_i,
  input wire logic byte_strobe,
  input wire logic [7:0] disk_byte,
  output logic [7:0] write_byte,
  output logic data_request_output,
  output logic head_load_output,
  input wire logic head_load_request,
  input wire logic write_request,
  output logic write_gate_output,
  output logic write_data_enable,
  input wire logic raw_read,
  input wire logic read_window_clock,
  output logic read_pulse_seen,
  output logic read_pulse_window,
  output logic [7:0] command_status
);
  import dsw_pkg::*;

  // ****************************************
  // wishbone slave
  // ****************************************
  dsw_wb_req_t req;
  logic bus_take;
  logic bus_write;
  logic [7:0] control;
  logic [7:0] data_latch;
  logic refused;
  logic busy;
  dsw_class_t cmd_class;
  logic double_density;
  logic slow_clock;
  logic start_req;
  logic start_ok;
  logic data_touch;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
  // the ack edge is the one edge at which the master commits
  assign bus_take = wb_ack_o;
  assign bus_write = bus_take && req.we && req.sel[0];
  assign double_density = control[`DSW_CTRL_DD_BIT];
  assign slow_clock = control[`DSW_CTRL_SLOW_BIT];
  assign start_req = bus_write && (req.adr == `DSW_ADDR_CONTROL) && req.dat[`DSW_CTRL_START_BIT];
  assign data_touch = bus_take && (req.adr == `DSW_ADDR_DATA);

  function automatic logic is_transfer(input dsw_class_t c);
    is_transfer = (c != DSW_CLASS_POSITION);
  endfunction : is_transfer

  function automatic logic is_write(input dsw_class_t c);
    is_write = (c == DSW_CLASS_WRITE_SECTOR) || (c == DSW_CLASS_WRITE_TRACK);
  endfunction : is_write

  // not-ready also blocks a new transfer while master reset holds
  assign start_ok = start_req && !(is_transfer(dsw_class_t'(req.dat[2:0])) && (!drive_i.ready || master_reset_input));

  always_ff @(posedge mclk)
  begin
    if (reset)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      wb_dat_o <= 32'h0000_0000;
    else if (req.cyc && req.stb && !wb_ack_o)
    begin
      case (req.adr)
        `DSW_ADDR_STATUS: wb_dat_o <= {24'h00_0000, command_status};
        `DSW_ADDR_CONTROL: wb_dat_o <= {24'h00_0000, 1'b0, refused, control[5:0]};
        `DSW_ADDR_DATA: wb_dat_o <= {24'h00_0000, data_latch};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // command class and busy
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
      control <= `DSW_CTRL_RESET;
    else if (bus_write && (req.adr == `DSW_ADDR_CONTROL) && (!req.dat[`DSW_CTRL_START_BIT] || start_ok))
      control <= {2'b00, req.dat[5:0]};
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      cmd_class <= DSW_CLASS_POSITION;
    else if (start_ok)
      cmd_class <= dsw_class_t'(req.dat[2:0]);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      refused <= 1'b0;
    else if (start_req)
      refused <= !start_ok;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      busy <= 1'b0;
    else if (start_ok)
      busy <= 1'b1;
    else if (event_i.cmd_done || master_reset_input)
      busy <= 1'b0;
  end

  // ****************************************
  // sticky error flags
  // ****************************************
  // a new command is the status update; an event in that cycle still sets
  logic seek_err;
  logic crc_err;
  logic rec_missing;
  logic deleted;
  logic wr_fault;
  logic wr_prot;
  logic lost_data;
  logic lost_event;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      seek_err <= 1'b0;
      crc_err <= 1'b0;
      rec_missing <= 1'b0;
      deleted <= 1'b0;
      wr_fault <= 1'b0;
      wr_prot <= 1'b0;
      lost_data <= 1'b0;
    end
    else
    begin
      seek_err <= event_i.seek_error || (seek_err && !start_ok);
      crc_err <= event_i.crc_error || (crc_err && !start_ok);
      rec_missing <= event_i.record_missing_flag || (rec_missing && !start_ok);
      deleted <= event_i.deleted_mark || (deleted && !start_ok);
      wr_fault <= event_i.write_fault || (wr_fault && !start_ok);
      wr_prot <= event_i.write_protect_hit || (wr_prot && !start_ok);
      lost_data <= lost_event || (lost_data && !start_ok);
    end
  end

  // ****************************************
  // data latch and data request
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
      data_latch <= `DSW_DATA_RESET;
    else if (byte_strobe && busy && !is_write(cmd_class))
      data_latch <= disk_byte;
    else if (bus_write && (req.adr == `DSW_ADDR_DATA))
      data_latch <= req.dat[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      write_byte <= 8'h00;
    else if (byte_strobe && busy && is_write(cmd_class))
      write_byte <= data_latch;
  end

  // latch full on reads, emptied on writes: both raise the request
  always_ff @(posedge mclk)
  begin
    if (reset)
      data_request_output <= 1'b0;
    else if (byte_strobe && busy && is_transfer(cmd_class))
      data_request_output <= 1'b1;
    else if (data_touch || start_ok)
      data_request_output <= 1'b0;
  end

  // ****************************************
  // lost data timer
  // ****************************************
  logic [12:0] byte_cnt;
  logic [12:0] byte_limit;

  function automatic logic [12:0] byte_cycles(input logic dd, input logic slow);
    logic [12:0] cyc;
    cyc = dd ? 13'(`DSW_BITS_PER_BYTE * `DSW_CELL_DD_CYC) : 13'(`DSW_BITS_PER_BYTE * `DSW_CELL_SD_CYC);
    if (slow)
      cyc = dd ? 13'(2 * `DSW_BITS_PER_BYTE * `DSW_CELL_DD_CYC) : 13'(BYTE_SLOW_SD_CYCLES);
    byte_cycles = cyc;
  endfunction : byte_cycles

  assign byte_limit = byte_cycles(double_density, slow_clock);
  // the next disk byte while the request is still pending is an overrun
  assign lost_event = data_request_output && !data_touch && (byte_strobe || (byte_cnt >= byte_limit - 13'd1));

  always_ff @(posedge mclk)
  begin
    if (reset)
      byte_cnt <= 13'd0;
    else if (!data_request_output || data_touch || lost_event)
      byte_cnt <= 13'd0;
    else
      byte_cnt <= byte_cnt + 13'd1;
  end

  // ****************************************
  // write gate sequencing
  // ****************************************
  dsw_gate_t gate_state;
  dsw_gate_t next_gate_state;
  logic [8:0] gate_cnt;
  logic [8:0] gate_limit;
  logic gate_go;

  function automatic logic [8:0] gate_cycles(input logic dd, input logic slow);
    logic [8:0] cyc;
    cyc = dd ? 9'(`DSW_GATE_DD_CYC) : 9'(`DSW_GATE_SD_CYC);
    gate_cycles = slow ? {cyc[7:0], 1'b0} : cyc;
  endfunction : gate_cycles

  assign gate_limit = gate_cycles(double_density, slow_clock);
  assign gate_go = write_request && busy && is_write(cmd_class) && !wr_prot && drive_i.write_protect_input_n;

  always_comb
  begin
    next_gate_state = gate_state;
    case (gate_state)
      DSW_GATE_IDLE:
        if (gate_go)
          next_gate_state = DSW_GATE_LEAD;
      DSW_GATE_LEAD:
        if (gate_cnt == gate_limit - 9'd1)
          next_gate_state = DSW_GATE_ACTIVE;
      DSW_GATE_ACTIVE:
        if (!write_request)
          next_gate_state = DSW_GATE_TRAIL;
      DSW_GATE_TRAIL:
        if (gate_cnt == gate_limit - 9'd1)
          next_gate_state = DSW_GATE_IDLE;
      default:
        next_gate_state = DSW_GATE_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset || master_reset_input)
      gate_state <= DSW_GATE_IDLE;
    else
      gate_state <= next_gate_state;
  end

  always_ff @(posedge mclk)
  begin
    if (reset || next_gate_state != gate_state)
      gate_cnt <= 9'd0;
    else if (gate_state == DSW_GATE_LEAD || gate_state == DSW_GATE_TRAIL)
      gate_cnt <= gate_cnt + 9'd1;
  end

  assign write_gate_output = (gate_state != DSW_GATE_IDLE);
  assign write_data_enable = (gate_state == DSW_GATE_ACTIVE);

  // ****************************************
  // head load and raw read sampling
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (reset || master_reset_input)
      head_load_output <= 1'b0;
    else
      head_load_output <= head_load_request;
  end

  logic raw_read_d;

  always_ff @(posedge mclk)
  begin
    if (reset)
      raw_read_d <= 1'b0;
    else
      raw_read_d <= raw_read;
  end

  // window level is recorded as seen; neither level is rejected
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      read_pulse_seen <= 1'b0;
      read_pulse_window <= 1'b0;
    end
    else
    begin
      read_pulse_seen <= raw_read && !raw_read_d;
      if (raw_read && !raw_read_d)
        read_pulse_window <= read_window_clock;
    end
  end

  // ****************************************
  // status multiplexer
  // ****************************************
  logic [7:0] next_status;

  always_comb
  begin
    next_status = 8'h00;
    next_status[`DSW_STATUS_NOT_READY] = !drive_i.ready || master_reset_input;
    next_status[`DSW_STATUS_BUSY] = busy;
    case (cmd_class)
      DSW_CLASS_POSITION:
      begin
        next_status[6] = !drive_i.write_protect_input_n;
        next_status[5] = head_load_output && drive_i.head_engage_input;
        next_status[4] = seek_err;
        next_status[3] = crc_err;
        next_status[2] = !drive_i.track_zero_input_n;
        next_status[1] = !drive_i.index_pulse_input_n;
      end
      DSW_CLASS_READ_ADDR, DSW_CLASS_READ_SECTOR:
      begin
        next_status[5] = (cmd_class == DSW_CLASS_READ_SECTOR) && deleted;
        next_status[4] = rec_missing;
        next_status[3] = crc_err;
        next_status[2] = lost_data;
        next_status[1] = data_request_output;
      end
      DSW_CLASS_WRITE_SECTOR:
      begin
        next_status[6] = wr_prot;
        next_status[5] = wr_fault;
        next_status[4] = rec_missing;
        next_status[3] = crc_err;
        next_status[2] = lost_data;
        next_status[1] = data_request_output;
      end
      DSW_CLASS_WRITE_TRACK:
      begin
        next_status[6] = wr_prot;
        next_status[5] = wr_fault;
        next_status[2] = lost_data;
        next_status[1] = data_request_output;
      end
      default:
      begin
        next_status[2] = lost_data;
        next_status[1] = data_request_output;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      command_status <= 8'h80;
    else
      command_status <= next_status;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_not_ready;
    @(posedge mclk) disable iff (reset) (!drive_i.ready || master_reset_input) |=> command_status[7];
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("not-ready bit missing");

  property p_refuse;
    @(posedge mclk) disable iff (reset)
      (start_req && is_transfer(dsw_class_t'(req.dat[2:0])) && !drive_i.ready && !busy) |=> !busy && refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("transfer started while not ready");

  property p_head;
    @(posedge mclk) disable iff (reset)
      (cmd_class == DSW_CLASS_POSITION) |=> command_status[5] == $past(head_load_output && drive_i.head_engage_input);
  endproperty
  a_head: assert property (p_head) else $error("head loaded bit wrong");

  property p_track0;
    @(posedge mclk) disable iff (reset)
      (cmd_class == DSW_CLASS_POSITION && !drive_i.track_zero_input_n) |=> command_status[2];
  endproperty
  a_track0: assert property (p_track0) else $error("track zero bit wrong");

  property p_busy;
    @(posedge mclk) disable iff (reset) start_ok |=> busy ##1 command_status[0];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");

  property p_read_wp;
    @(posedge mclk) disable iff (reset) (is_transfer(cmd_class) && !is_write(cmd_class)) |=> !command_status[6];
  endproperty
  a_read_wp: assert property (p_read_wp) else $error("protect bit set on read");

  property p_seek_clear;
    @(posedge mclk) disable iff (reset) (start_ok && !event_i.seek_error) |=> !seek_err;
  endproperty
  a_seek_clear: assert property (p_seek_clear) else $error("seek error not cleared");

  property p_lost;
    @(posedge mclk) disable iff (reset)
      (data_request_output && byte_strobe && !data_touch && !start_ok) |=> lost_data;
  endproperty
  a_lost: assert property (p_lost) else $error("overrun not flagged");

  property p_drq;
    @(posedge mclk) disable iff (reset)
      (is_transfer(cmd_class) && !start_ok) |=> command_status[1] == $past(data_request_output);
  endproperty
  a_drq: assert property (p_drq) else $error("request bit mismatch");

  // lead and trail run hundreds of cycles, so a counter holds the quiet gate time
  logic [8:0] gate_quiet_cnt;

  always_ff @(posedge mclk)
  begin
    if (reset || !write_gate_output || write_data_enable)
      gate_quiet_cnt <= 9'h000;
    else if (gate_quiet_cnt != 9'h1ff)
      gate_quiet_cnt <= gate_quiet_cnt + 9'h001;
  end

  property p_lead;
    @(posedge mclk) disable iff (reset || master_reset_input)
      $rose(write_data_enable) |-> gate_quiet_cnt >= gate_limit;
  endproperty
  a_lead: assert property (p_lead) else $error("write data before lead time");

  // a gate cut by master reset owes no trail time
  property p_trail;
    @(posedge mclk) disable iff (reset || master_reset_input)
      ($fell(write_gate_output) && !$past(master_reset_input)) |-> gate_quiet_cnt >= gate_limit;
  endproperty
  a_trail: assert property (p_trail) else $error("write gate dropped early");

  c_refused: cover property (@(posedge mclk) disable iff (reset) start_req && !start_ok);
  c_write_gate: cover property (@(posedge mclk) disable iff (reset) $fell(write_gate_output));
  c_lost: cover property (@(posedge mclk) disable iff (reset) $rose(lost_data));
  c_done: cover property (@(posedge mclk) disable iff (reset) $fell(busy));
endmodule : dsw_status_word

// ---- test/dsw_drive_model.sv ----
`timescale 1ns/1ps
// ****************************************
// drive side of the status word
// ****************************************
// counts are scaled down; a real index pulse lasts far longer
module dsw_drive_model #(
  parameter int ENGAGE_CYC = 8,
  parameter int INDEX_PERIOD = 200,
  parameter int INDEX_WIDTH = 10
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic head_load_output,
  input wire logic ready,
  input wire logic protect,
  input wire logic on_track0,
  input wire logic index_on,
  output dsw_pkg::dsw_drive_t drive_o
);
  import dsw_pkg::*;
  int eng_cnt;
  int idx_cnt;
  // head only counts as engaged after a settle time, drops at once
  always_ff @(posedge mclk)
  begin
    if (reset || !head_load_output)
      eng_cnt <= 0;
    else if (eng_cnt < ENGAGE_CYC)
      eng_cnt <= eng_cnt + 1;
  end
  always_ff @(posedge mclk)
  begin
    if (reset || idx_cnt == INDEX_PERIOD - 1)
      idx_cnt <= 0;
    else
      idx_cnt <= idx_cnt + 1;
  end
  assign drive_o = '{ready, !protect, eng_cnt == ENGAGE_CYC, !on_track0, !(index_on && idx_cnt < INDEX_WIDTH)};
endmodule : dsw_drive_model

// ---- test/test_dsw_status_word.sv ----
`timescale 1ns/1ps
module test_dsw_status_word;
  import dsw_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o;
  logic master_reset_input = 1'b0, ready = 1'b1, protect = 1'b0, on_track0 = 1'b0, index_on = 1'b0;
  dsw_drive_t drive_i;
  dsw_event_t event_i = '0;
  logic byte_strobe = 1'b0, head_load_request = 1'b0, write_request = 1'b0;
  logic raw_read = 1'b0, read_window_clock = 1'b0;
  logic [7:0] disk_byte = 8'h00, write_byte, command_status;
  logic data_request_output, head_load_output, write_gate_output, write_data_enable;
  logic read_pulse_seen, read_pulse_window;
  int n_errors = 0, total_checks = 0, cycles = 0, n;
  always #5 mclk = ~mclk;
  // ****************************************
  // instances
  // ****************************************
  // small slow-clock byte time keeps the run short
  dsw_status_word #(.BYTE_SLOW_SD_CYCLES(64)) DUT (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .master_reset_input(master_reset_input), .drive_i(drive_i),
    .event_i(event_i), .byte_strobe(byte_strobe), .disk_byte(disk_byte), .write_byte(write_byte),
    .data_request_output(data_request_output), .head_load_output(head_load_output),
    .head_load_request(head_load_request), .write_request(write_request),
    .write_gate_output(write_gate_output), .write_data_enable(write_data_enable), .raw_read(raw_read),
    .read_window_clock(read_window_clock), .read_pulse_seen(read_pulse_seen),
    .read_pulse_window(read_pulse_window), .command_status(command_status));
  dsw_drive_model drive (.mclk(mclk), .reset(reset), .head_load_output(head_load_output), .ready(ready),
    .protect(protect), .on_track0(on_track0), .index_on(index_on), .drive_o(drive_i));
  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // classic single cycle; data taken at the ack edge only
  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, dat};
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic pulse(input dsw_event_t e);
    @(posedge mclk);
    event_i <= e;
    @(posedge mclk);
    event_i <= '0;
  endtask : pulse
  task automatic strobe(input logic [7:0] b);
    @(posedge mclk);
    byte_strobe <= 1'b1;
    disk_byte <= b;
    @(posedge mclk);
    byte_strobe <= 1'b0;
  endtask : strobe
  // finish any running command first, then start the next
  task automatic start(input logic [7:0] ctrl);
    pulse(7'h40);
    wb(1'b1, 4'h4, ctrl);
  endtask : start
  // status is registered, so let events and pins settle
  task automatic st(input string what, input logic [7:0] mask, input logic [7:0] exp);
    tick(3);
    chk(what, {24'h0, exp}, {24'h0, command_status & mask});
  endtask : st
  function automatic logic sig(input int k);
    case (k)
      0: return write_gate_output;
      1: return write_data_enable;
      2: return drive_i.index_pulse_input_n;
      default: return read_pulse_seen;
    endcase
  endfunction : sig
  task automatic count_to(input int k, input logic lvl);
    n = 0;
    while (sig(k) !== lvl && n < 1000)
    begin
      tick(1);
      n++;
    end
    if (n >= 1000)
    begin
      n_errors++;
      $display("ERROR wait on signal %0d expected %0d seen timeout", k, lvl);
    end
  endtask : count_to
  // ****************************************
  // timeout
  // ****************************************
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    tick(5);
    chk("status in reset", 32'h80, {24'h0, command_status});
    tick(7);
    reset <= 1'b0;
    wb(1'b0, 4'h0, 8'h00);
    chk("status idle", 32'h0, rd);
    master_reset_input <= 1'b1;
    st("forced not ready", 8'h81, 8'h80);
    master_reset_input <= 1'b0;
    protect <= 1'b1;
    on_track0 <= 1'b1;
    head_load_request <= 1'b1;
    tick(12);
    st("positioning pins", 8'hfe, 8'h64);
    index_on <= 1'b1;
    count_to(2, 1'b0);
    st("index", 8'h02, 8'h02);
    index_on <= 1'b0;
    start(8'h80);
    st("busy", 8'h01, 8'h01);
    pulse(7'h30);
    st("seek and checksum", 8'h19, 8'h19);
    start(8'h80);
    st("flags cleared", 8'h19, 8'h01);
    pulse(7'h40);
    st("idle", 8'h01, 8'h00);
    on_track0 <= 1'b0;
    head_load_request <= 1'b0;
    ready <= 1'b0;
    wb(1'b1, 4'h4, 8'h82);
    wb(1'b0, 4'h4, 8'h00);
    chk("refused flag", 32'h40, rd & 32'h40);
    st("not started", 8'h81, 8'h80);
    ready <= 1'b1;
    start(8'h82);
    pulse(7'h1c);
    st("read sector flags", 8'h7d, 8'h39);
    strobe(8'ha5);
    st("data request", 8'h06, 8'h02);
    wb(1'b0, 4'h8, 8'h00);
    chk("data latch", 32'ha5, rd);
    st("request served", 8'h06, 8'h00);
    strobe(8'h5a);
    strobe(8'h3c);
    st("lost on overrun", 8'h04, 8'h04);
    protect <= 1'b0;
    start(8'h83);
    pulse(7'h1c);
    st("read track zeros", 8'h7d, 8'h01);
    start(8'h81);
    pulse(7'h1c);
    st("read address flags", 8'h7d, 8'h19);
    start(8'h85);
    pulse(7'h1f);
    st("write track flags", 8'h7d, 8'h61);
    start(8'h84);
    pulse(7'h03);
    st("write faults", 8'h61, 8'h61);
    start(8'h84);
    st("write flags cleared", 8'h61, 8'h01);
    wb(1'b1, 4'h8, 8'h69);
    strobe(8'h00);
    tick(1);
    chk("write byte", 32'h69, {24'h0, write_byte});
    st("write request", 8'h02, 8'h02);
    // double density, then slow single density
    for (int i = 0; i < 2; i++)
    begin
      start(i ? 8'h92 : 8'h8a);
      strobe(8'h11);
      tick((i ? 64 : 1600) - 10);
      chk("no loss yet", 32'h0, {31'h0, command_status[2]});
      tick(20);
      chk("loss after byte time", 32'h1, {31'h0, command_status[2]});
    end
    // double density, then single density
    for (int i = 0; i < 2; i++)
    begin
      start(i ? 8'h84 : 8'h8c);
      write_request <= 1'b1;
      count_to(0, 1'b1);
      count_to(1, 1'b1);
      chk("gate lead", i ? 200 : 100, n);
      write_request <= 1'b0;
      count_to(1, 1'b0);
      count_to(0, 1'b0);
      chk("gate trail", i ? 200 : 100, n);
    end
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk);
      read_window_clock <= !i[0];
      raw_read <= 1'b1;
      count_to(3, 1'b1);
      chk("raw pulse seen", 32'h1, {31'h0, n < 4});
      chk("window level", {31'h0, !i[0]}, {31'h0, read_pulse_window});
      raw_read <= 1'b0;
      tick(3);
    end
    wb(1'b0, 4'hc, 8'h00);
    chk("unmapped read", 32'h0, rd);
    give_verdict();
  end
endmodule : test_dsw_status_word
